// File: hw/slwd_pkg.sv
// Constants, types and register layout of the segment LCD waveform driver.
// Assumes a single 200 MHz system clock and a word-wide AHB-Lite bus.
package slwd_pkg;

    // ------------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // ------------------------------------------------------------------
    localparam logic [7:0] LCD_CLOCK_SETUP_IDX = 8'h4F;
    localparam logic [7:0] LCD_CONTROL_IDX     = 8'h51;
    localparam logic [7:0] SEG_DATA_FIRST_IDX  = 8'h52;
    localparam logic [7:0] SEG_DATA_LAST_IDX   = 8'h5F;
    localparam logic [7:0] OPTION_REG_TWO_IDX  = 8'h60;
    localparam int         NUM_SEG_REGS        = 14;
    localparam int         NUM_FP              = 27;
    localparam int         NUM_BP_FIXED        = 3;
    localparam int         FIRST_SHARED_FP     = 19;
    localparam int         HIGH_SHARED_FP      = 23;
    localparam int         NUM_PORT_PINS       = 8;

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int CTL_ENABLE_BIT  = 7;
    localparam int CTL_FAST_BIT    = 6;
    localparam int CTL_LOWI_BIT    = 5;
    localparam int CTL_CONTRAST_LO = 0;
    localparam int CLK_PULSE_LO    = 5;
    localparam int CLK_MUX_LO      = 3;
    localparam int CLK_DIV_LO      = 0;
    localparam int OPT_LOW_BIT     = 0;
    localparam int OPT_HIGH_BIT    = 1;
    localparam logic [7:0] LAST_SEG_MASK = 8'h0F;
    localparam logic [7:0] OPT_RESET     = 8'h03;

    // ------------------------------------------------------------------
    // Encodings.
    // ------------------------------------------------------------------
    localparam logic [1:0] MUX_STATIC  = 2'h0;
    localparam logic [1:0] MUX_THIRD   = 2'h1;
    localparam logic [1:0] MUX_QUARTER = 2'h2;
    localparam logic [1:0] PULSE_NONE  = 2'h3;
    localparam logic [2:0] DIV_RESERVED = 3'h7;
    localparam int         PULSE_SHIFT_BASE = 5;
    localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;

    // Panel drive levels of the 1/3 bias ladder; supply level is zero.
    typedef enum logic [1:0] {
        LVL_VLCD = 2'h0,
        LVL_V1   = 2'h1,
        LVL_V2   = 2'h2,
        LVL_V3   = 2'h3
    } slwd_lvl_t;

    typedef enum logic [1:0] {
        LAD_OFF   = 2'h0,
        LAD_HIGHI = 2'h1,
        LAD_LOWI  = 2'h2
    } slwd_ladder_t;

    typedef struct packed {
        logic       enable;
        logic       fast;
        logic       lowi;
        logic [3:0] contrast;
        logic [1:0] pulse;
        logic [1:0] mux;
        logic [2:0] div;
    } slwd_cfg_t;

    typedef struct packed {
        logic [NUM_BP_FIXED-1:0][1:0] bp;
        logic [1:0]                   shared;
        logic [NUM_FP-1:1][1:0]       fp;
    } slwd_pins_t;

    // Base clock divide ratio in reference clock cycles.
    function automatic logic [16:0] div_ratio(input logic [2:0] code);
        unique case (code)
            3'h0:    div_ratio = 17'h00080;
            3'h1:    div_ratio = 17'h00100;
            3'h2:    div_ratio = 17'h00200;
            3'h3:    div_ratio = 17'h00400;
            3'h4:    div_ratio = 17'h04000;
            3'h5:    div_ratio = 17'h08000;
            3'h6:    div_ratio = 17'h10000;
            default: div_ratio = 17'h00000;
        endcase
    endfunction

endpackage

// File: hw/slwd_base_timer.sv
// Base clock timer: half-period ticks and the fast-charge window.
// Assumes ref_tick is a one-cycle pulse per rising crystal reference edge.
module slwd_base_timer
    import slwd_pkg::*;
(
    input  wire logic       clk,        // System clock.
    input  wire logic       rst,        // Synchronous reset.
    input  wire logic       run,        // Driver enabled.
    input  wire logic       ref_tick,   // Reference clock edge.
    input  wire logic [2:0] div_code,   // Base clock divider code.
    input  wire logic [1:0] pulse_code, // Charge pulse width code.
    output logic            half_tick,  // Half base period boundary.
    output logic            charge_on   // Fast-charge window active.
);

    logic [15:0] cnt_q;
    logic [16:0] ratio;
    logic [15:0] half_len;
    logic [15:0] win_len;

    assign ratio    = div_ratio(div_code);
    assign half_len = ratio[16:1];
    assign win_len  = 16'(ratio >> (PULSE_SHIFT_BASE + int'(pulse_code)));

    // ------------------------------------------------------------------
    // Half period counter in reference cycles.
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || !run || div_code == DIV_RESERVED) begin // see R12
            cnt_q     <= '0;
            half_tick <= 1'b0;
        end else if (ref_tick) begin
            if (cnt_q >= half_len - 16'h0001) begin // see R13
                cnt_q     <= '0;
                half_tick <= 1'b1;
            end else begin
                cnt_q     <= cnt_q + 16'h0001;
                half_tick <= 1'b0;
            end
        end else begin
            half_tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Charge window opens at each switching edge.
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || !run || pulse_code == PULSE_NONE) begin
            charge_on <= 1'b0;
        end else begin
            charge_on <= (cnt_q < win_len); // see R10 see R17
        end
    end

    AST_WINDOW_AT_EDGE: assert property (@(posedge clk) disable iff (rst) // see R17
        (half_tick && run && pulse_code != PULSE_NONE
         && div_code != DIV_RESERVED) |=> charge_on)
        else $error("Charge window did not open at switching edge.");

endmodule

// File: hw/slwd_driver.sv
// Segment LCD waveform driver: AHB-Lite registers, sequencer, pin levels.
// Assumes CRYSTAL_REF_CLK is an asynchronous pin well below SYS_CLK / 2.
// Each panel pin is reported as a 2-bit ladder level code.
// Summary of operation
// R1: Thirty panel pins; eight frontplanes double as port C pins.
// R2: Shared pin is fourth backplane only at 1/4 multiplex, else frontplane.
// R3: At 1/3 multiplex a frame is three base periods; fourth BP unused.
// R4: Static frame is one base period; only first backplane driven.
// R5: Frontplanes 19 to 26 go to LCD or port by two config bits.
// R6: Frontplane waveform follows multiplex ratio and stored segment bits.
// R7: Enable bit is read/write, reset clear, gates all waveform drive.
// R8: Low-current and fast-charge bits pick 37k, 146k or fast charge.
// R9: Four-bit contrast; 0000 maximum, 1111 minimum contrast.
// R10: Charge pulse width code picks /32, /64, /128 per half period.
// R11: Multiplex field: 00 static, 01 third, 10 quarter; reset clear.
// R12: Divider code 000..110 divides reference by 128 up to 65536.
// R13: Divider input is the crystal reference clock.
// R14: Sixteen registers: control, clock and fourteen segment data.
// R15: Segment bit one turns segment on; each data register holds two FPs; here the last holds FP26 only.
// R16: Disabled: every pin at supply level, ladder disconnected.
// R17: Fast charge applies high current briefly at every switching edge.
// R18: One backplane phase per base period; FP uses active backplane bit.
//
// Decided for this implementation: the AHB-Lite register port.
module slwd_driver
    import slwd_pkg::*;
(
    input  wire logic        SYS_CLK,         // System clock, 200 MHz.
    input  wire logic        RESET,           // Synchronous reset.
    input  wire logic        HSEL,            // Slave select.
    input  wire logic [31:0] HADDR,           // Byte address.
    input  wire logic [1:0]  HTRANS,          // Transfer type.
    input  wire logic        HWRITE,          // Write when high.
    input  wire logic [2:0]  HSIZE,           // Transfer size.
    input  wire logic [31:0] HWDATA,          // Write data.
    input  wire logic        HREADY,          // Bus ready in.
    output logic             HREADYOUT,       // Slave ready.
    output logic             HRESP,           // Response, always OKAY.
    output logic [31:0]      HRDATA,          // Read data.
    input  wire logic        CRYSTAL_REF_CLK, // Crystal reference pin.
    output slwd_pins_t       PANEL,           // Levels of the 30 pins.
    output logic             SHARED_IS_BP,    // Shared pin is backplane.
    output logic [7:0]       PORT_IO,         // FP19..FP26 given to port.
    output slwd_ladder_t     LADDER,          // Ladder resistor setting.
    output logic [3:0]       CONTRAST         // Bias step, 0 is maximum.
);

    // ------------------------------------------------------------------
    // Register state.
    // ------------------------------------------------------------------
    slwd_cfg_t  cfg_q;
    logic [7:0] seg_q [NUM_SEG_REGS];
    logic [7:0] opt_q;
    logic       wr_pend_q;
    logic       rd_pend_q;
    logic [7:0] idx_q;
    logic       xs1_q;
    logic       xs2_q;
    logic       xs3_q;
    logic       ref_tick;
    logic       half_tick;
    logic       charge_on;
    logic       half_q;
    logic [1:0] phase_q;
    slwd_pins_t pins_d;
    logic       take;
    logic [7:0] addr_idx;

    // Decodes a register index; any other index reads zero.
    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = (idx == LCD_CLOCK_SETUP_IDX) || (idx == LCD_CONTROL_IDX)
                 || (idx == OPTION_REG_TWO_IDX)
                 || (idx >= SEG_DATA_FIRST_IDX && idx <= SEG_DATA_LAST_IDX);
    endfunction

    function automatic logic is_seg(input logic [7:0] idx);
        is_seg = (idx >= SEG_DATA_FIRST_IDX) && (idx <= SEG_DATA_LAST_IDX);
    endfunction

    // Index of the last backplane phase in one frame.
    function automatic logic [1:0] last_phase(input logic [1:0] mux);
        unique case (mux)
            MUX_THIRD:   last_phase = 2'h2;
            MUX_QUARTER: last_phase = 2'h3;
            default:     last_phase = 2'h0;
        endcase
    endfunction

    function automatic slwd_lvl_t bp_lvl(input logic act, input logic h);
        if (act) begin
            bp_lvl = h ? LVL_V3 : LVL_VLCD;
        end else begin
            bp_lvl = h ? LVL_V1 : LVL_V2;
        end
    endfunction

    function automatic slwd_lvl_t fp_lvl(input logic on, input logic h,
                                         input logic stat);
        if (on) begin
            fp_lvl = h ? LVL_VLCD : LVL_V3;
        end else if (stat) begin
            fp_lvl = h ? LVL_V3 : LVL_VLCD;
        end else begin
            fp_lvl = h ? LVL_V2 : LVL_V1;
        end
    endfunction

    // ------------------------------------------------------------------
    // AHB-Lite slave. Writes complete with no wait; reads take one wait
    // state so a read right behind a write sees the new value.
    // ------------------------------------------------------------------
    assign addr_idx = HADDR[9:2];
    assign take     = HSEL && HREADY && HTRANS[1] && (HADDR[31:10] == '0);

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            idx_q     <= '0;
        end else begin
            if (HREADY) begin
                wr_pend_q <= take && HWRITE;
                rd_pend_q <= take && !HWRITE;
                idx_q     <= addr_idx;
            end else begin
                rd_pend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
            HRDATA    <= '0;
        end else begin
            HRESP <= 1'b0;
            if (HREADY && take && !HWRITE) begin
                HREADYOUT <= 1'b0;
            end else begin
                HREADYOUT <= 1'b1;
            end
            if (rd_pend_q) begin
                HRDATA <= '0;
                if (idx_q == LCD_CONTROL_IDX) begin
                    HRDATA[CTL_ENABLE_BIT] <= cfg_q.enable;
                    HRDATA[CTL_FAST_BIT]   <= cfg_q.fast;
                    HRDATA[CTL_LOWI_BIT]   <= cfg_q.lowi;
                    HRDATA[CTL_CONTRAST_LO +: 4] <= cfg_q.contrast;
                end else if (idx_q == LCD_CLOCK_SETUP_IDX) begin
                    HRDATA[CLK_PULSE_LO +: 2] <= cfg_q.pulse;
                    HRDATA[CLK_MUX_LO +: 2]   <= cfg_q.mux;
                    HRDATA[CLK_DIV_LO +: 3]   <= cfg_q.div;
                end else if (idx_q == OPTION_REG_TWO_IDX) begin
                    HRDATA[7:0] <= opt_q;
                end else if (is_mapped(idx_q) && is_seg(idx_q)) begin
                    HRDATA[7:0] <= seg_q[4'(idx_q - SEG_DATA_FIRST_IDX)];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Control, clock and option registers.
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            cfg_q <= '0; // see R7 see R8 see R10 see R11 see R12
            opt_q <= OPT_RESET;
        end else if (wr_pend_q) begin
            if (idx_q == LCD_CONTROL_IDX) begin
                cfg_q.enable   <= HWDATA[CTL_ENABLE_BIT]; // see R7
                cfg_q.fast     <= HWDATA[CTL_FAST_BIT];
                cfg_q.lowi     <= HWDATA[CTL_LOWI_BIT];
                cfg_q.contrast <= HWDATA[CTL_CONTRAST_LO +: 4]; // see R9
            end else if (idx_q == LCD_CLOCK_SETUP_IDX) begin
                cfg_q.pulse <= HWDATA[CLK_PULSE_LO +: 2];
                cfg_q.mux   <= HWDATA[CLK_MUX_LO +: 2]; // see R11
                cfg_q.div   <= HWDATA[CLK_DIV_LO +: 3];
            end else if (idx_q == OPTION_REG_TWO_IDX) begin
                opt_q <= HWDATA[7:0] & OPT_RESET;
            end
        end
    end

    // Fourteen segment data registers, two frontplanes each except the last, which holds one.
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            for (int i = 0; i < NUM_SEG_REGS; i++) begin
                seg_q[i] <= '0;
            end
        end else if (wr_pend_q && is_seg(idx_q)) begin // see R14
            if (idx_q == SEG_DATA_LAST_IDX) begin
                seg_q[NUM_SEG_REGS-1] <= HWDATA[7:0] & LAST_SEG_MASK;
            end else begin
                seg_q[4'(idx_q - SEG_DATA_FIRST_IDX)] <= HWDATA[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Crystal reference: two-stage synchroniser, then edge detect.
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            xs1_q <= 1'b0;
            xs2_q <= 1'b0;
            xs3_q <= 1'b0;
        end else begin
            xs1_q <= CRYSTAL_REF_CLK;
            xs2_q <= xs1_q;
            xs3_q <= xs2_q;
        end
    end

    assign ref_tick = xs2_q && !xs3_q; // see R13

    slwd_base_timer u_timer (
        .clk        (SYS_CLK),
        .rst        (RESET),
        .run        (cfg_q.enable),
        .ref_tick   (ref_tick),
        .div_code   (cfg_q.div),
        .pulse_code (cfg_q.pulse),
        .half_tick  (half_tick),
        .charge_on  (charge_on)
    );

    // ------------------------------------------------------------------
    // Sequencer: two halves per base period, one phase per base period.
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (RESET || !cfg_q.enable) begin
            half_q  <= 1'b0;
            phase_q <= '0;
        end else if (phase_q > last_phase(cfg_q.mux)) begin
            half_q  <= 1'b0;
            phase_q <= '0;
        end else if (half_tick) begin
            half_q <= !half_q;
            if (half_q) begin // see R18
                phase_q <= (phase_q == last_phase(cfg_q.mux)) ? 2'h0
                                                              : phase_q + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin levels.
    // ------------------------------------------------------------------
    always_comb begin
        logic stat;
        stat   = (last_phase(cfg_q.mux) == 2'h0);
        pins_d = '0; // see R16
        if (cfg_q.enable) begin // see R7
            for (int b = 0; b < NUM_BP_FIXED; b++) begin
                if (2'(b) <= last_phase(cfg_q.mux)) begin // see R3 see R4
                    pins_d.bp[b] = bp_lvl(2'(b) == phase_q, half_q);
                end
            end
            if (cfg_q.mux == MUX_QUARTER) begin // see R2
                pins_d.shared = bp_lvl(phase_q == 2'h3, half_q);
            end else begin
                pins_d.shared = fp_lvl(seg_q[0][phase_q], half_q, stat);
            end
            for (int f = 1; f < NUM_FP; f++) begin // see R6 see R15
                if (!(f >= FIRST_SHARED_FP && !opt_q[(f >= HIGH_SHARED_FP)
                                            ? OPT_HIGH_BIT : OPT_LOW_BIT]))
                begin
                    pins_d.fp[f] = fp_lvl(
                        seg_q[f / 2][3'((f % 2) * 4) + 3'(phase_q)],
                        half_q, stat);
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            PANEL        <= '0;
            SHARED_IS_BP <= 1'b0;
            PORT_IO      <= '0;
            LADDER       <= LAD_OFF;
            CONTRAST     <= '0;
        end else begin
            PANEL        <= pins_d; // see R1
            SHARED_IS_BP <= (cfg_q.mux == MUX_QUARTER); // see R2
            PORT_IO      <= {{4{!opt_q[OPT_HIGH_BIT]}},
                             {4{!opt_q[OPT_LOW_BIT]}}}; // see R5
            CONTRAST     <= cfg_q.contrast; // see R9
            if (!cfg_q.enable) begin
                LADDER <= LAD_OFF; // see R16
            end else if (!cfg_q.lowi) begin
                LADDER <= LAD_HIGHI; // see R8
            end else if (cfg_q.fast && charge_on) begin
                LADDER <= LAD_HIGHI; // see R17
            end else begin
                LADDER <= LAD_LOWI;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    AST_BLANK_DISABLED: assert property (@(posedge SYS_CLK) // see R16
        disable iff (RESET) !cfg_q.enable |=> (PANEL == '0 && LADDER == LAD_OFF))
        else $error("Disabled driver did not blank the panel.");

    AST_LADDER_HIGH: assert property (@(posedge SYS_CLK) // see R8
        disable iff (RESET) (cfg_q.enable && !cfg_q.lowi) |=> LADDER == LAD_HIGHI)
        else $error("Low-current clear did not select high current.");

    AST_LADDER_LOW: assert property (@(posedge SYS_CLK) // see R8
        disable iff (RESET)
        (cfg_q.enable && cfg_q.lowi && !cfg_q.fast) |=> LADDER == LAD_LOWI)
        else $error("Low-current without fast charge not low.");

    AST_SHARED_ROLE: assert property (@(posedge SYS_CLK) // see R2
        disable iff (RESET)
        1'b1 |=> SHARED_IS_BP == ($past(cfg_q.mux) == MUX_QUARTER))
        else $error("Shared pin role does not follow multiplex ratio.");

    AST_STATIC_PHASE: assert property (@(posedge SYS_CLK) // see R4
        disable iff (RESET)
        (cfg_q.mux == MUX_STATIC) ##1 (cfg_q.mux == MUX_STATIC) |->
        phase_q == 2'h0 && PANEL.bp[1] == LVL_VLCD)
        else $error("Static mode left phase zero or drove BP1.");

    AST_THIRD_RANGE: assert property (@(posedge SYS_CLK) // see R3
        disable iff (RESET)
        (cfg_q.mux == MUX_THIRD) [*2] |-> phase_q < 2'h3)
        else $error("Third multiplex reached a fourth phase.");

    AST_RESET_CLEARS: assert property (@(posedge SYS_CLK) // see R7
        RESET |=> (cfg_q == '0 && LADDER == LAD_OFF))
        else $error("Reset did not clear the settings.");

    AST_PORT_LOW: assert property (@(posedge SYS_CLK) // see R5
        disable iff (RESET)
        !opt_q[OPT_LOW_BIT] |=> (PORT_IO[3:0] == 4'hF
                                 && PANEL.fp[FIRST_SHARED_FP] == LVL_VLCD))
        else $error("Port share bit did not release FP19.");

    AST_READ_WAIT: assert property (@(posedge SYS_CLK) // see R14
        disable iff (RESET)
        (take && !HWRITE) |=> !HREADYOUT ##1 HREADYOUT)
        else $error("Read did not take exactly one wait state.");

    AST_FAST_CHARGE: assert property (@(posedge SYS_CLK) // see R17
        disable iff (RESET) (cfg_q.enable && cfg_q.lowi && cfg_q.fast)
        |=> LADDER == ($past(charge_on) ? LAD_HIGHI : LAD_LOWI))
        else $error("Fast charge did not follow the charge window.");

endmodule

// File: tb/slwd_panel_model.sv
// Panel glass model: watches the first backplane and times its swings.
// Assumes PANEL changes only just after a rising system clock edge.
module slwd_panel_model
    import slwd_pkg::*;
(
    input  wire logic       clk,  // System clock.
    input  wire slwd_pins_t pins, // Panel drive levels.
    output int              gap   // Cycles between backplane swings.
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] prev_q = 2'h0;
    int         cnt    = 0;

    // --------------------------------------------------------------
    // Swing timer
    // --------------------------------------------------------------
    // The glass draws charge at every swing, so the gap between two
    // swings is the half period that the sequencer really keeps.
    always @(posedge clk) begin
        prev_q <= pins.bp[0];
        cnt <= cnt + 1;
        if (pins.bp[0] !== prev_q) begin
            gap <= cnt + 1;
            cnt <= 0;
        end
    end
endmodule

// File: tb/slwd_driver_tb.sv
// Self-checking bench of the segment LCD waveform driver.
// Assumes one slave on the bus and a reference of 20 system cycles.
module slwd_driver_tb
    import slwd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic         sys_clk = 1'b0;
    logic         reset   = 1'b1;
    logic         hsel    = 1'b0;
    logic         hwrite  = 1'b0;
    logic         ref_clk = 1'b0;
    logic [31:0]  haddr   = 32'h0;
    logic [31:0]  hwdata  = 32'h0;
    logic [1:0]   htrans  = 2'h0;
    logic         hreadyout;
    logic         hresp;
    logic [31:0]  hrdata;
    slwd_pins_t   panel;
    logic         shared_is_bp;
    logic [7:0]   port_io;
    slwd_ladder_t ladder;
    logic [3:0]   contrast;
    logic [7:0]   exp_q[$];
    logic         dph = 1'b0;
    logic [7:0]   r;
    int           gap;
    int           seed = 32'hb75e;
    int           cycles = 0;
    int           ref_cnt = 0;
    int           num_errors = 0;
    int           total_checks = 0;

    slwd_driver slwd_driver_inst (.SYS_CLK(sys_clk), .RESET(reset),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata),
        .CRYSTAL_REF_CLK(ref_clk), .PANEL(panel),
        .SHARED_IS_BP(shared_is_bp), .PORT_IO(port_io), .LADDER(ladder),
        .CONTRAST(contrast));
    slwd_panel_model slwd_panel_model_inst (.clk(sys_clk), .pins(panel),
        .gap(gap));

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("Mismatches %0d, checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // Bus master; a read notes its expected byte for the monitor.
    // --------------------------------------------------------------
    task automatic bus(input logic [7:0] idx, input logic wr,
                       input logic [7:0] d);
        if (!wr) exp_q.push_back(d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
    endtask

    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    always @(posedge sys_clk) begin
        if (dph && hreadyout === 1'b1) begin
            check(hrdata, {24'h0, exp_q.pop_front()});
            check(hresp, 1'b0);
        end
        if (hreadyout === 1'b1) dph <= hsel && htrans[1] && !hwrite;
    end

    // Reference pin is made on the bus clock so its period is exact.
    always @(posedge sys_clk) begin
        ref_cnt <= (ref_cnt == 9) ? 0 : ref_cnt + 1;
        if (ref_cnt == 9) ref_clk <= ~ref_clk;
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors++;
            close_out();
        end
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        bus(LCD_CONTROL_IDX, 1'b0, 8'h00);
        bus(LCD_CLOCK_SETUP_IDX, 1'b0, 8'h00);
        settle();
        check(panel, '0);
        r = 8'($random(seed));
        bus(LCD_CONTROL_IDX, 1'b1, r & 8'h7F);
        bus(LCD_CONTROL_IDX, 1'b0, r & 8'h6F);
        settle();
        check(contrast, r[3:0]);
        check(ladder, LAD_OFF);
        bus(LCD_CONTROL_IDX, 1'b1, 8'hC0);
        settle();
        check(ladder, LAD_HIGHI);
        bus(LCD_CONTROL_IDX, 1'b1, 8'hA0);
        settle();
        check(ladder, LAD_LOWI);
        r = 8'($random(seed));
        bus(LCD_CLOCK_SETUP_IDX, 1'b1, r);
        bus(LCD_CLOCK_SETUP_IDX, 1'b0, r & 8'h7F);
        for (int m = 0; m < 3; m++) begin
            bus(LCD_CLOCK_SETUP_IDX, 1'b1, 8'(m << 3));
            settle();
            check(shared_is_bp, m == 2);
        end
        bus(OPTION_REG_TWO_IDX, 1'b1, 8'h02);
        settle();
        check(port_io, 8'h0F);
        bus(8'h40, 1'b1, 8'h5A);
        bus(8'h40, 1'b0, 8'h00);
        bus(SEG_DATA_LAST_IDX, 1'b1, 8'hFF);
        bus(SEG_DATA_LAST_IDX, 1'b0, LAST_SEG_MASK);
        bus(SEG_DATA_FIRST_IDX, 1'b1, 8'h10);
        bus(SEG_DATA_FIRST_IDX + 8'h1, 1'b1, 8'h00);
        bus(LCD_CONTROL_IDX, 1'b1, 8'hE0);
        for (int d = 0; d < 2; d++) begin
            bus(LCD_CLOCK_SETUP_IDX, 1'b1, 8'(d));
            repeat (4000 << d) @(posedge sys_clk);
            #1;
            check(gap, 1280 << d);
            check(panel.fp[2], panel.bp[0]);
            check(panel.fp[1], 2'h3 - panel.bp[0]);
        end
        bus(LCD_CONTROL_IDX, 1'b1, 8'h00);
        settle();
        check(panel, '0);
        close_out();
    end
endmodule
